// [core/ofd_consts.svh]
// constants for the operand field decoder
`ifndef OFD_CONSTS_SVH
`define OFD_CONSTS_SVH
`define OFD_MOD_HI 7
`define OFD_MOD_LO 6
`define OFD_MID_HI 5
`define OFD_MID_LO 3
`define OFD_RM_HI 2
`define OFD_RM_LO 0
`define OFD_OPC_SEG2_HI 4
`define OFD_OPC_SEG2_LO 3
`define OFD_MOD_REG 2'h3
`define OFD_MOD_NODISP 2'h0
`define OFD_MOD_DISP8 2'h1
`define OFD_MOD_DISP16 2'h2
`define OFD_RM_SIB 3'h4
`define OFD_RM_DIRECT 3'h6
`define OFD_SEG3_FIRST_RSVD 3'h6
`define OFD_IDX_RESET 3'h0
`endif

// [core/ofd_pkg.sv]
// types for the operand field decoder
package ofd_pkg;
  typedef enum logic [1:0] {OFD_W_BYTE_LO, OFD_W_BYTE_HI, OFD_W_FULL16, OFD_W_FULL32} ofd_width_t;
  typedef enum logic [1:0] {OFD_SRC_OPCODE, OFD_SRC_MID, OFD_SRC_RM} ofd_reg_src_t;
  typedef enum logic [1:0] {OFD_SEGSRC_NONE, OFD_SEGSRC_TWO, OFD_SEGSRC_THREE} ofd_seg_src_t;
  typedef enum logic [2:0] {
    OFD_SEG_NONE, OFD_SEG_EXTRA, OFD_SEG_CODE, OFD_SEG_STACK, OFD_SEG_DATA, OFD_SEG_ADDED_A, OFD_SEG_ADDED_B
  } ofd_seg_t;
  typedef enum logic [1:0] {OFD_BASE_NONE, OFD_BASE_GP, OFD_BASE_FRAME} ofd_base_t;
  typedef enum logic [1:0] {OFD_INDEX_NONE, OFD_INDEX_SRC, OFD_INDEX_DEST} ofd_index_t;
  typedef enum logic [1:0] {OFD_DISP_NONE, OFD_DISP_EIGHT, OFD_DISP_SIXTEEN} ofd_disp_t;
endpackage

// [core/ofd_reg_decode.sv]
// general register selector decode, used for the reg and rm fields
`timescale 1ns/1ps
`default_nettype none
module ofd_reg_decode
  import ofd_pkg::*;
(
  // selector and size controls
  input wire logic [2:0] sel_i,
  input wire logic has_w_i,
  input wire logic w_i,
  input wire logic op32_i,
  // decoded register
  output logic [2:0] idx_o,
  output ofd_width_t width_o
);
  always_comb begin
    idx_o = sel_i;
    width_o = op32_i ? OFD_W_FULL32 : OFD_W_FULL16;
    // byte registers when w is 0
    if (has_w_i && !w_i) begin
      idx_o = {1'b0, sel_i[1:0]};
      width_o = sel_i[2] ? OFD_W_BYTE_HI : OFD_W_BYTE_LO;
    end
  end
endmodule // ofd_reg_decode
`default_nettype wire

// [core/ofd_decoder.sv]
// operand field decoder: register, segment and 16-bit address mode decode
// Behaviour
// - register selector comes from opcode bits, modrm middle field or rm field
// - without size bit, selector 0..7 picks full-size registers 0..7
// - size bit 0: 0..3 low byte, 4..7 second byte of registers 0..3
// - two-bit segment selector: extra, code, stack, data
// - three-bit selector adds two segments; codes 6 and 7 reserved
// - addressing from modrm byte unless instruction has fixed addressing
// - scale-index-base byte follows only in 32-bit addressing, rm 4, mod not 3
// - modrm middle bits are opcode extension or register selector
// - 16-bit address table used only when address size is 16; 32-bit table left to the wider path
// - mod 3 makes rm a register, decoded like the selector
// - size bit 0 is byte operand, 1 is full operation size
// - size prefixes invert default operand and address size
`timescale 1ns/1ps
`default_nettype none
`include "ofd_consts.svh"
module ofd_decoder
  import ofd_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // fetched instruction bytes
  input wire logic valid_i,
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] modrm_i,
  // instruction class controls
  input wire logic has_modrm_i,
  input wire logic mid_is_reg_i,
  input wire ofd_reg_src_t reg_src_i,
  input wire ofd_seg_src_t seg_src_i,
  input wire logic has_w_i,
  input wire logic w_i,
  // size state
  input wire logic default_32_i,
  input wire logic opsize_prefix_i,
  input wire logic addrsize_prefix_i,
  // register operand results
  output logic valid_o,
  output logic op32_o,
  output logic addr32_o,
  output logic reg_valid_o,
  output logic [2:0] reg_idx_o,
  output ofd_width_t reg_width_o,
  output logic [2:0] opext_o,
  output logic rm_is_reg_o,
  output logic [2:0] rm_idx_o,
  output ofd_width_t rm_width_o,
  // segment results
  output ofd_seg_t seg_o,
  output logic seg_invalid_o,
  // memory address results
  output logic mem_valid_o,
  output logic sib_follows_o,
  output ofd_base_t ea_base_o,
  output ofd_index_t ea_index_o,
  output ofd_disp_t ea_disp_o,
  output ofd_seg_t ea_seg_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] mode;
  logic [2:0] mid;
  logic [2:0] rm;
  logic op32;
  logic addr32;
  logic [2:0] next_sel;
  logic [2:0] next_reg_idx;
  ofd_width_t next_reg_width;
  logic [2:0] next_rm_idx;
  ofd_width_t next_rm_width;
  ofd_seg_t next_seg;
  logic next_seg_invalid;
  logic next_mem;
  ofd_base_t next_base;
  ofd_index_t next_index;
  ofd_disp_t next_disp;

  assign mode = modrm_i[`OFD_MOD_HI:`OFD_MOD_LO];
  assign mid = modrm_i[`OFD_MID_HI:`OFD_MID_LO];
  assign rm = modrm_i[`OFD_RM_HI:`OFD_RM_LO];
  assign op32 = default_32_i ^ opsize_prefix_i;
  assign addr32 = default_32_i ^ addrsize_prefix_i;

  always_comb begin
    case (reg_src_i)
      OFD_SRC_OPCODE: next_sel = opcode_i[`OFD_RM_HI:`OFD_RM_LO];
      OFD_SRC_MID: next_sel = mid;
      OFD_SRC_RM: next_sel = rm;
      default: next_sel = mid;
    endcase
  end

  ofd_reg_decode u_reg_dec (
    .sel_i(next_sel),
    .has_w_i(has_w_i),
    .w_i(w_i),
    .op32_i(op32),
    .idx_o(next_reg_idx),
    .width_o(next_reg_width)
  );

  ofd_reg_decode u_rm_dec (
    .sel_i(rm),
    .has_w_i(has_w_i),
    .w_i(w_i),
    .op32_i(op32),
    .idx_o(next_rm_idx),
    .width_o(next_rm_width)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_seg_invalid = 1'b0;
    next_seg = OFD_SEG_NONE;
    case (seg_src_i)
      OFD_SEGSRC_TWO: begin
        case (opcode_i[`OFD_OPC_SEG2_HI:`OFD_OPC_SEG2_LO])
          2'h0: next_seg = OFD_SEG_EXTRA;
          2'h1: next_seg = OFD_SEG_CODE;
          2'h2: next_seg = OFD_SEG_STACK;
          default: next_seg = OFD_SEG_DATA;
        endcase
      end
      OFD_SEGSRC_THREE: begin
        case (mid)
          3'h0: next_seg = OFD_SEG_EXTRA;
          3'h1: next_seg = OFD_SEG_CODE;
          3'h2: next_seg = OFD_SEG_STACK;
          3'h3: next_seg = OFD_SEG_DATA;
          3'h4: next_seg = OFD_SEG_ADDED_A;
          3'h5: next_seg = OFD_SEG_ADDED_B;
          default: next_seg_invalid = 1'b1;
        endcase
      end
      default: next_seg = OFD_SEG_NONE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory form only with modrm byte
  assign next_mem = has_modrm_i && (mode != `OFD_MOD_REG);

  // 16-bit table, 32-bit table left to the wider path
  always_comb begin
    next_base = OFD_BASE_NONE;
    next_index = OFD_INDEX_NONE;
    next_disp = OFD_DISP_NONE;
    if (next_mem && !addr32) begin
      case (rm)
        3'h0, 3'h1, 3'h2, 3'h3: begin
          next_base = rm[1] ? OFD_BASE_FRAME : OFD_BASE_GP;
          next_index = rm[0] ? OFD_INDEX_DEST : OFD_INDEX_SRC;
        end
        3'h4: next_index = OFD_INDEX_SRC;
        3'h5: next_index = OFD_INDEX_DEST;
        // rm 6 with displacement is frame pointer
        3'h6: next_base = (mode == `OFD_MOD_NODISP) ? OFD_BASE_NONE : OFD_BASE_FRAME;
        default: next_base = OFD_BASE_GP;
      endcase
      case (mode)
        `OFD_MOD_DISP8: next_disp = OFD_DISP_EIGHT;
        `OFD_MOD_DISP16: next_disp = OFD_DISP_SIXTEEN;
        default: next_disp = (rm == `OFD_RM_DIRECT) ? OFD_DISP_SIXTEEN : OFD_DISP_NONE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one register stage
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      valid_o <= 1'b0;
      op32_o <= 1'b0;
      addr32_o <= 1'b0;
    end else begin
      valid_o <= valid_i;
      op32_o <= op32;
      addr32_o <= addr32;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_valid_o <= 1'b0;
      reg_idx_o <= `OFD_IDX_RESET;
      reg_width_o <= OFD_W_BYTE_LO;
      opext_o <= `OFD_IDX_RESET;
    end else begin
      reg_valid_o <= valid_i && (reg_src_i != OFD_SRC_MID || mid_is_reg_i);
      reg_idx_o <= next_reg_idx;
      reg_width_o <= next_reg_width;
      opext_o <= mid_is_reg_i ? `OFD_IDX_RESET : mid;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rm_is_reg_o <= 1'b0;
      rm_idx_o <= `OFD_IDX_RESET;
      rm_width_o <= OFD_W_BYTE_LO;
    end else begin
      rm_is_reg_o <= valid_i && has_modrm_i && (mode == `OFD_MOD_REG);
      rm_idx_o <= next_rm_idx;
      rm_width_o <= next_rm_width;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seg_o <= OFD_SEG_NONE;
      seg_invalid_o <= 1'b0;
    end else begin
      seg_o <= next_seg;
      seg_invalid_o <= valid_i && next_seg_invalid;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_valid_o <= 1'b0;
      sib_follows_o <= 1'b0;
      ea_base_o <= OFD_BASE_NONE;
      ea_index_o <= OFD_INDEX_NONE;
      ea_disp_o <= OFD_DISP_NONE;
      ea_seg_o <= OFD_SEG_NONE;
    end else begin
      mem_valid_o <= valid_i && next_mem;
      sib_follows_o <= valid_i && next_mem && addr32 && (rm == `OFD_RM_SIB);
      ea_base_o <= next_base;
      ea_index_o <= next_index;
      ea_disp_o <= next_disp;
      ea_seg_o <= (next_mem && !addr32) ? ((next_base == OFD_BASE_FRAME) ? OFD_SEG_STACK : OFD_SEG_DATA)
                                        : OFD_SEG_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_valid_follows: assert property (valid_i |=> valid_o)
    else $error("valid did not follow by one cycle");
  chk_full_no_w: assert property (valid_i && !has_w_i && reg_src_i == OFD_SRC_OPCODE
    |=> reg_idx_o == $past(opcode_i[2:0]) && reg_width_o == (op32_o ? OFD_W_FULL32 : OFD_W_FULL16))
    else $error("full register decode wrong");
  chk_byte_high: assert property (valid_i && has_w_i && !w_i && reg_src_i == OFD_SRC_MID && mid[2]
    |=> reg_width_o == OFD_W_BYTE_HI && reg_idx_o == {1'b0, $past(modrm_i[4:3])})
    else $error("high byte decode wrong");
  chk_w_one_full: assert property (valid_i && has_w_i && w_i
    |=> reg_width_o inside {OFD_W_FULL16, OFD_W_FULL32})
    else $error("w set gave byte width");
  chk_size_prefix: assert property (valid_i |=> op32_o == ($past(default_32_i) ^ $past(opsize_prefix_i)))
    else $error("operand size toggle wrong");
  chk_seg_two: assert property (valid_i && seg_src_i == OFD_SEGSRC_TWO && opcode_i[4:3] == 2'h2
    |=> seg_o == OFD_SEG_STACK)
    else $error("segment two decode wrong");
  chk_seg_rsvd: assert property (valid_i && seg_src_i == OFD_SEGSRC_THREE && mid[2:1] == 2'h3
    |=> seg_invalid_o)
    else $error("reserved segment not flagged");
  chk_sib_cond: assert property (sib_follows_o |-> addr32_o && mem_valid_o)
    else $error("sib flagged outside 32-bit memory form");
  chk_direct16: assert property (valid_i && has_modrm_i && !addr32 && mode == 2'h0 && rm == 3'h6
    |=> ea_base_o == OFD_BASE_NONE && ea_disp_o == OFD_DISP_SIXTEEN && ea_seg_o == OFD_SEG_DATA)
    else $error("direct address decode wrong");
  chk_frame_disp: assert property (valid_i && has_modrm_i && !addr32 && mode == 2'h1 && rm == 3'h6
    |=> ea_base_o == OFD_BASE_FRAME && ea_seg_o == OFD_SEG_STACK && ea_disp_o == OFD_DISP_EIGHT)
    else $error("frame pointer displacement decode wrong");
  chk_rm_reg: assert property (rm_is_reg_o |-> !mem_valid_o && ea_base_o == OFD_BASE_NONE)
    else $error("register form decoded as memory");

  cov_seg_rsvd: cover property (seg_invalid_o);
  cov_sib: cover property (sib_follows_o);
  cov_rm_byte: cover property (rm_is_reg_o && rm_width_o == OFD_W_BYTE_HI);
  cov_disp16: cover property (mem_valid_o && ea_disp_o == OFD_DISP_SIXTEEN && ea_index_o == OFD_INDEX_SRC);
endmodule // ofd_decoder
`default_nettype wire

// [test/tb.sv]
// self-checking bench for the operand field decoder
`timescale 1ns/1ps
`default_nettype none
module tb
  import ofd_pkg::*;
;
  typedef struct {
    logic v, op32, a32, rv, rr, si, mv, sb;
    logic [2:0] ri, ox, mi;
    ofd_width_t rw, mw;
    ofd_seg_t sg, es;
    ofd_base_t b;
    ofd_index_t x;
    ofd_disp_t d;
  } ofd_exp_t;
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, valid_i = 1'b0, has_modrm_i = 1'b0, mid_is_reg_i = 1'b0;
  logic has_w_i = 1'b0, w_i = 1'b0, default_32_i = 1'b0, opsize_prefix_i = 1'b0, addrsize_prefix_i = 1'b0;
  logic [7:0] opcode_i = 8'h00, modrm_i = 8'h00;
  ofd_reg_src_t reg_src_i = OFD_SRC_OPCODE;
  ofd_seg_src_t seg_src_i = OFD_SEGSRC_NONE;
  logic valid_o, op32_o, addr32_o, reg_valid_o, rm_is_reg_o, seg_invalid_o, mem_valid_o, sib_follows_o;
  logic [2:0] reg_idx_o, opext_o, rm_idx_o;
  ofd_width_t reg_width_o, rm_width_o;
  ofd_seg_t seg_o, ea_seg_o;
  ofd_base_t ea_base_o;
  ofd_index_t ea_index_o;
  ofd_disp_t ea_disp_o;
  ofd_exp_t q[$];
  ofd_exp_t r;
  integer seed = 74;
  int err_total = 0, compares = 0;
  ofd_decoder ofd_decoder_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .valid_i(valid_i), .opcode_i(opcode_i),
    .modrm_i(modrm_i), .has_modrm_i(has_modrm_i), .mid_is_reg_i(mid_is_reg_i), .reg_src_i(reg_src_i),
    .seg_src_i(seg_src_i), .has_w_i(has_w_i), .w_i(w_i), .default_32_i(default_32_i),
    .opsize_prefix_i(opsize_prefix_i), .addrsize_prefix_i(addrsize_prefix_i), .valid_o(valid_o), .op32_o(op32_o),
    .addr32_o(addr32_o), .reg_valid_o(reg_valid_o), .reg_idx_o(reg_idx_o), .reg_width_o(reg_width_o),
    .opext_o(opext_o), .rm_is_reg_o(rm_is_reg_o), .rm_idx_o(rm_idx_o), .rm_width_o(rm_width_o), .seg_o(seg_o),
    .seg_invalid_o(seg_invalid_o), .mem_valid_o(mem_valid_o), .sib_follows_o(sib_follows_o),
    .ea_base_o(ea_base_o), .ea_index_o(ea_index_o), .ea_disp_o(ea_disp_o), .ea_seg_o(ea_seg_o));
  always #2.5 ref_clk_i = ~ref_clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [4:0] regdec(input logic [2:0] s, input logic hw, input logic w, input logic o32);
    if (hw && !w) return {1'b0, s[1:0], s[2] ? OFD_W_BYTE_HI : OFD_W_BYTE_LO};
    return {s, o32 ? OFD_W_FULL32 : OFD_W_FULL16};
  endfunction
  function automatic ofd_seg_t segdec(input logic [2:0] c);
    case (c)
      3'h0: return OFD_SEG_EXTRA;
      3'h1: return OFD_SEG_CODE;
      3'h2: return OFD_SEG_STACK;
      3'h3: return OFD_SEG_DATA;
      3'h4: return OFD_SEG_ADDED_A;
      3'h5: return OFD_SEG_ADDED_B;
      default: return OFD_SEG_NONE;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic step(input logic [7:0] m, input logic v);
    ofd_exp_t e;
    logic [7:0] op;
    logic hm, mr, hw, w, d32, opp, adp;
    logic [4:0] t;
    logic [2:0] sel;
    logic [1:0] md;
    ofd_reg_src_t rs;
    ofd_seg_src_t ss;
    @(posedge ref_clk_i);
    op = 8'($random(seed));
    {hm, mr, hw, w, d32, opp, adp} = 7'($random(seed));
    rs = ofd_reg_src_t'(2'(unsigned'($random(seed)) % 3));
    ss = ofd_seg_src_t'(2'(unsigned'($random(seed)) % 3));
    valid_i <= v;
    opcode_i <= op;
    modrm_i <= m;
    has_modrm_i <= hm;
    mid_is_reg_i <= mr;
    has_w_i <= hw;
    w_i <= w;
    default_32_i <= d32;
    opsize_prefix_i <= opp;
    addrsize_prefix_i <= adp;
    reg_src_i <= rs;
    seg_src_i <= ss;
    md = m[7:6];
    e.v = v;
    e.op32 = d32 ^ opp;
    e.a32 = d32 ^ adp;
    sel = rs == OFD_SRC_OPCODE ? op[2:0] : rs == OFD_SRC_MID ? m[5:3] : m[2:0];
    e.rv = v && (rs != OFD_SRC_MID || mr);
    t = regdec(sel, hw, w, e.op32);
    e.ri = t[4:2];
    e.rw = ofd_width_t'(t[1:0]);
    e.ox = mr ? 3'h0 : m[5:3];
    e.rr = v && hm && md == 2'h3;
    t = regdec(m[2:0], hw, w, e.op32);
    e.mi = t[4:2];
    e.mw = ofd_width_t'(t[1:0]);
    e.si = 1'b0;
    e.sg = OFD_SEG_NONE;
    if (ss == OFD_SEGSRC_TWO) e.sg = segdec({1'b0, op[4:3]});
    if (ss == OFD_SEGSRC_THREE) begin
      e.sg = segdec(m[5:3]);
      e.si = v && m[5:4] == 2'h3;
    end
    e.mv = v && hm && md != 2'h3;
    e.sb = e.mv && e.a32 && m[2:0] == 3'h4;
    e.b = OFD_BASE_NONE;
    e.x = OFD_INDEX_NONE;
    e.d = OFD_DISP_NONE;
    e.es = OFD_SEG_NONE;
    if (e.mv && !e.a32) begin
      e.es = OFD_SEG_DATA;
      e.d = md == 2'h1 ? OFD_DISP_EIGHT : md == 2'h2 ? OFD_DISP_SIXTEEN : OFD_DISP_NONE;
      if (m[2:0] < 3'h6) e.x = m[0] ? OFD_INDEX_DEST : OFD_INDEX_SRC;
      case (m[2:0])
        3'h0, 3'h1, 3'h7: e.b = OFD_BASE_GP;
        3'h2, 3'h3: begin
          e.b = OFD_BASE_FRAME;
          e.es = OFD_SEG_STACK;
        end
        3'h6: begin
          if (md == 2'h0) begin
            e.d = OFD_DISP_SIXTEEN;
          end else begin
            e.b = OFD_BASE_FRAME;
            e.es = OFD_SEG_STACK;
          end
        end
        default: ;
      endcase
    end
    q.push_back(e);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge ref_clk_i) if (q.size() > 1) begin
    r = q.pop_front();
    chk("valid", valid_o, r.v);
    chk("op32", op32_o, r.op32);
    chk("addr32", addr32_o, r.a32);
    chk("reg_valid", reg_valid_o, r.rv);
    chk("rm_is_reg", rm_is_reg_o, r.rr);
    chk("seg_invalid", seg_invalid_o, r.si);
    chk("mem_valid", mem_valid_o, r.mv);
    chk("sib", sib_follows_o, r.sb);
    if (r.rv) chk("reg", {reg_idx_o, reg_width_o}, {r.ri, r.rw});
    if (r.v) begin
      chk("opext", opext_o, r.ox);
      chk("rm_reg", {rm_idx_o, rm_width_o}, {r.mi, r.mw});
      chk("seg", seg_o, r.sg);
    end
    if (r.mv) chk("ea", {ea_base_o, ea_index_o, ea_disp_o}, {r.b, r.x, r.d});
    if (r.mv) chk("ea_seg", ea_seg_o, r.es);
  end
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge ref_clk_i);
    #1 chk("rst_flags", {valid_o, mem_valid_o, seg_invalid_o, reg_valid_o}, 8'h00);
    @(posedge ref_clk_i) rst_n_i <= 1'b1;
    for (int i = 0; i < 256; i++) step(8'(i), 1'b1);
    repeat (2000) step(8'($random(seed)), ($random(seed) & 3) != 0);
    @(posedge ref_clk_i) rst_n_i <= 1'b0;
    q.delete();
    #1 chk("rst_mid", {valid_o, mem_valid_o, rm_is_reg_o, sib_follows_o}, 8'h00);
    @(posedge ref_clk_i) rst_n_i <= 1'b1;
    repeat (500) step(8'($random(seed)), 1'b1);
    repeat (3) @(posedge ref_clk_i);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
